//--- common/iep_pkg.sv
package iep_pkg;
  // register indexes; the byte address is four times the index
  localparam logic [7:0] IDX_PORT_WAKE  = 8'h96;
  localparam logic [7:0] IDX_MAIN_EN    = 8'ha8;
  localparam logic [7:0] IDX_AUX_EN     = 8'ha9;
  localparam logic [7:0] IDX_PRIO_LO_M  = 8'hb8;
  localparam logic [7:0] IDX_PRIO_HI_M  = 8'hb9;
  localparam logic [7:0] IDX_PRIO_LO_A  = 8'hba;
  localparam logic [7:0] IDX_PRIO_HI_A  = 8'hbb;
  localparam logic [7:0] IDX_FLAG_LO    = 8'hc0;
  localparam logic [7:0] IDX_FLAG_HI    = 8'hc1;
  localparam logic [7:0] IDX_EVT_STAT   = 8'hc2;
  localparam logic [7:0] IDX_EVT_MASK   = 8'hc3;
  localparam logic [7:0] IDX_SERVICE    = 8'hc4;

  // writable bits of each register
  localparam logic [7:0] MASK_PORT_WAKE = 8'h0f;
  localparam logic [7:0] MASK_MAIN_EN   = 8'hbf;
  localparam logic [7:0] MASK_SIX_BITS  = 8'h3f;
  localparam logic [7:0] MASK_EVT       = 8'h07;

  // values after reset
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [11:0] RST_FLAGS     = 12'h000;
  localparam logic [3:0]  RST_SERVICE   = 4'h0;
  localparam logic [2:0]  RST_EVT       = 3'h0;

  // field positions
  localparam int POS_GLOBAL_GATE = 7;
  localparam int POS_PIN0_EN     = 0;
  localparam int POS_PIN1_EN     = 2;
  localparam int POS_PIN2_EN     = 2;
  localparam int NUM_SRC         = 12;
  localparam int SRC_PIN0        = 0;
  localparam int SRC_PIN1        = 2;
  localparam int SRC_PORT1       = 7;
  localparam int SRC_PIN2        = 8;
  localparam int EVT_TAKE        = 0;
  localparam int EVT_PREEMPT     = 1;
  localparam int EVT_WAKE        = 2;

  // cpu power state as reported by the core
  typedef enum logic [1:0] {
    MODE_RUN  = 2'b00,
    MODE_IDLE = 2'b01,
    MODE_HALT = 2'b10,
    MODE_STOP = 2'b11
  } iep_mode_t;
endpackage

//--- core/iep_interrupt_enable_priority.sv
// Function
// - a pending enabled request goes to the cpu when no handler of equal or higher level is in service.
// - a request whose level is not above the running handler waits until that handler returns.
// - a request of higher level than the running handler preempts it.
// - after a preempting handler returns, the interrupted lower handler resumes, tracked per level.
// - dispatch of each source is gated by the main and aux enable registers.
// - each source level comes from one bit of a low priority register and one of its high partner.
// - bits 3 to 0 of the port wake register enable wake and interrupt of port-1 pins 3 to 0.
// - with the pin-0 enable set, a pin-0 event wakes from halt or stop whatever the global gate; its interrupt request needs the gate set.
// - priority bits high then low give level 3 (11) highest down to level 0 (00).
// - every source event sets its flag whatever the enable bits; a port-1 pin change sets the port flag only on an enabled pin.
// - any enabled interrupt wakes from idle, only pin sources wake from halt or stop.
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module iep_interrupt_enable_priority (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [9:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  input  wire logic [11:0] src_event_i,
  input  wire logic [3:0]  p1_change_i,
  input  wire logic [1:0]  cpu_mode_i,
  input  wire logic        cpu_ack_i,
  input  wire logic        cpu_reti_i,
  output logic             irq_req_o,
  output logic [3:0]       irq_id_o,
  output logic [1:0]       irq_level_o,
  output logic             wake_o,
  output logic             irq_o
);

  function automatic logic [1:0] src_level(input logic [11:0] hi,
                                           input logic [11:0] lo,
                                           input logic [3:0]  idx);
    src_level = {hi[idx], lo[idx]};
  endfunction

  // highest level that is in service, with a valid flag on top
  function automatic logic [2:0] top_level(input logic [3:0] svc);
    top_level = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (svc[k])
      begin
        top_level = {1'b1, 2'(k)};
      end
    end
  endfunction

  logic [7:0]  port_pin_wake_enable;
  logic [7:0]  main_enable_reg;
  logic [7:0]  aux_enable_reg;
  logic [7:0]  prio_low_main;
  logic [7:0]  prio_high_main;
  logic [7:0]  prio_low_aux;
  logic [7:0]  prio_high_aux;
  logic [11:0] irq_flag;
  logic [3:0]  in_service;
  logic [2:0]  evt_status;
  logic [2:0]  evt_mask;

  // bus decode
  wire [7:0] idx      = adr_i[9:2];
  wire       bus_req  = cyc_i && stb_i;
  wire       wr       = bus_req && we_i && ack_o && sel_i[0];
  wire [7:0] wb       = dat_i[7:0];
  wire       next_ack = bus_req && !ack_o;

  wire wr_port  = wr && (idx == iep_pkg::IDX_PORT_WAKE);
  wire wr_main  = wr && (idx == iep_pkg::IDX_MAIN_EN);
  wire wr_aux   = wr && (idx == iep_pkg::IDX_AUX_EN);
  wire wr_plm   = wr && (idx == iep_pkg::IDX_PRIO_LO_M);
  wire wr_phm   = wr && (idx == iep_pkg::IDX_PRIO_HI_M);
  wire wr_pla   = wr && (idx == iep_pkg::IDX_PRIO_LO_A);
  wire wr_pha   = wr && (idx == iep_pkg::IDX_PRIO_HI_A);
  wire wr_flo   = wr && (idx == iep_pkg::IDX_FLAG_LO);
  wire wr_fhi   = wr && (idx == iep_pkg::IDX_FLAG_HI);
  wire wr_stat  = wr && (idx == iep_pkg::IDX_EVT_STAT);
  wire wr_mask  = wr && (idx == iep_pkg::IDX_EVT_MASK);

  wire [7:0] rd_byte =
    (idx == iep_pkg::IDX_PORT_WAKE) ? port_pin_wake_enable :
    (idx == iep_pkg::IDX_MAIN_EN)   ? main_enable_reg :
    (idx == iep_pkg::IDX_AUX_EN)    ? aux_enable_reg :
    (idx == iep_pkg::IDX_PRIO_LO_M) ? prio_low_main :
    (idx == iep_pkg::IDX_PRIO_HI_M) ? prio_high_main :
    (idx == iep_pkg::IDX_PRIO_LO_A) ? prio_low_aux :
    (idx == iep_pkg::IDX_PRIO_HI_A) ? prio_high_aux :
    (idx == iep_pkg::IDX_FLAG_LO)   ? irq_flag[7:0] :
    (idx == iep_pkg::IDX_FLAG_HI)   ? {4'h0, irq_flag[11:8]} :
    (idx == iep_pkg::IDX_EVT_STAT)  ? {5'h00, evt_status} :
    (idx == iep_pkg::IDX_EVT_MASK)  ? {5'h00, evt_mask} :
    (idx == iep_pkg::IDX_SERVICE)   ? {4'h0, in_service} :
    8'h00;

  // per-source vectors in vector order
  wire        gate   = main_enable_reg[iep_pkg::POS_GLOBAL_GATE];
  wire [11:0] en_vec = {aux_enable_reg[5:0], main_enable_reg[5:0]};
  wire [11:0] lo_vec = {prio_low_aux[5:0], prio_low_main[5:0]};
  wire [11:0] hi_vec = {prio_high_aux[5:0], prio_high_main[5:0]};

  wire [2:0]  svc_top_v = top_level(in_service);
  wire        svc_any   = svc_top_v[2];
  wire [1:0]  svc_top   = svc_top_v[1:0];

  // port-1 pin changes only count on enabled pins
  wire        p1_hit  = |(p1_change_i & port_pin_wake_enable[3:0]);
  wire [11:0] set_vec = src_event_i | {4'h0, p1_hit, 7'h00};

  wire        take     = cpu_ack_i && irq_req_o;
  wire        preempt  = take && svc_any;
  wire [11:0] ack_clr  = take ? (12'h001 << irq_id_o) : 12'h000;
  wire [11:0] sw_clr   = {wr_fhi ? wb[3:0] : 4'h0, wr_flo ? wb : 8'h00};
  wire [11:0] next_flag = (irq_flag & ~ack_clr & ~sw_clr) | set_vec;

  wire [3:0] take_mask = take ? (4'h1 << irq_level_o) : 4'h0;
  wire [3:0] pop_mask  = (cpu_reti_i && svc_any) ?
                         (4'h1 << svc_top) : 4'h0;
  wire [3:0] next_svc  = (in_service & ~pop_mask) | take_mask;

  // arbitration: highest level first, lowest vector on a tie
  logic       found;
  logic [3:0] best_id;
  logic [1:0] best_lvl;
  logic [1:0] cur_lvl;
  always_comb
  begin
    found    = 1'b0;
    best_id  = 4'h0;
    best_lvl = 2'h0;
    cur_lvl  = 2'h0;
    for (int i = iep_pkg::NUM_SRC - 1; i >= 0; i--)
    begin
      cur_lvl = src_level(hi_vec, lo_vec, 4'(i));
      if (irq_flag[i] && en_vec[i] && gate &&
          (!svc_any || cur_lvl > svc_top) &&
          (!found || cur_lvl >= best_lvl))
      begin
        found    = 1'b1;
        best_id  = 4'(i);
        best_lvl = cur_lvl;
      end
    end
  end

  wire next_req = found && !take;

  // wake: idle on any enabled pending source, halt/stop on pins only
  wire mode_deep = (cpu_mode_i == iep_pkg::MODE_HALT) ||
                   (cpu_mode_i == iep_pkg::MODE_STOP);
  wire mode_idle = (cpu_mode_i == iep_pkg::MODE_IDLE);
  wire any_enabled = gate && |(irq_flag & en_vec);
  wire pin_wake =
    (src_event_i[iep_pkg::SRC_PIN0] &&
     main_enable_reg[iep_pkg::POS_PIN0_EN]) ||
    (src_event_i[iep_pkg::SRC_PIN1] &&
     main_enable_reg[iep_pkg::POS_PIN1_EN]) ||
    (src_event_i[iep_pkg::SRC_PIN2] &&
     aux_enable_reg[iep_pkg::POS_PIN2_EN]) ||
    p1_hit;
  wire next_wake = mode_deep ? pin_wake : (mode_idle && any_enabled);

  wire [2:0] evt_set = {next_wake, preempt, take};
  wire [2:0] evt_clr = wr_stat ? wb[2:0] : 3'h0;
  wire [2:0] next_status = (evt_status & ~evt_clr) | evt_set;
  wire       next_irq = |(next_status & evt_mask);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= next_ack;
      if (next_ack)
      begin
        dat_o <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_pin_wake_enable <= iep_pkg::RST_BYTE;
      main_enable_reg      <= iep_pkg::RST_BYTE;
      aux_enable_reg       <= iep_pkg::RST_BYTE;
      prio_low_main        <= iep_pkg::RST_BYTE;
      prio_high_main       <= iep_pkg::RST_BYTE;
      prio_low_aux         <= iep_pkg::RST_BYTE;
      prio_high_aux        <= iep_pkg::RST_BYTE;
      evt_mask             <= iep_pkg::RST_EVT;
    end
    else
    begin
      if (wr_port)
        port_pin_wake_enable <= wb & iep_pkg::MASK_PORT_WAKE;
      if (wr_main)
        main_enable_reg <= wb & iep_pkg::MASK_MAIN_EN;
      if (wr_aux)
        aux_enable_reg <= wb & iep_pkg::MASK_SIX_BITS;
      if (wr_plm)
        prio_low_main <= wb & iep_pkg::MASK_SIX_BITS;
      if (wr_phm)
        prio_high_main <= wb & iep_pkg::MASK_SIX_BITS;
      if (wr_pla)
        prio_low_aux <= wb & iep_pkg::MASK_SIX_BITS;
      if (wr_pha)
        prio_high_aux <= wb & iep_pkg::MASK_SIX_BITS;
      if (wr_mask)
        evt_mask <= wb[2:0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_flag    <= iep_pkg::RST_FLAGS;
      in_service  <= iep_pkg::RST_SERVICE;
      evt_status  <= iep_pkg::RST_EVT;
      irq_req_o   <= 1'b0;
      irq_id_o    <= 4'h0;
      irq_level_o <= 2'h0;
      wake_o      <= 1'b0;
      irq_o       <= 1'b0;
    end
    else
    begin
      irq_flag    <= next_flag;
      in_service  <= next_svc;
      evt_status  <= next_status;
      irq_req_o   <= next_req;
      irq_id_o    <= best_id;
      irq_level_o <= best_lvl;
      wake_o      <= next_wake;
      irq_o       <= next_irq;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_gate_blocks: assert property (
    irq_req_o |-> $past(gate))
    else $error("request raised with the global gate clear");

  chk_src_enabled: assert property (
    irq_req_o |->
      ($past(en_vec & irq_flag) & (12'h001 << irq_id_o)) != 12'h000)
    else $error("request for a disabled or idle source");

  chk_level_above: assert property (
    irq_req_o && $past(svc_any) |-> irq_level_o > $past(svc_top))
    else $error("request not above the level in service");

  chk_level_code: assert property (
    irq_req_o && $stable(hi_vec) && $stable(lo_vec) |->
      irq_level_o == src_level(hi_vec, lo_vec, irq_id_o))
    else $error("request level does not match priority bits");

  chk_flag_capture: assert property (
    src_event_i != 12'h000 |=>
      (irq_flag & $past(src_event_i)) == $past(src_event_i))
    else $error("event did not set its flag");

  chk_ack_nests: assert property (
    take |=> in_service[$past(irq_level_o)] && !irq_req_o)
    else $error("taken request not recorded as in service");

  chk_reti_pops: assert property (
    cpu_reti_i && svc_any && !take |=> !in_service[$past(svc_top)] &&
      ((in_service | (4'h1 << $past(svc_top))) == $past(in_service)))
    else $error("return did not resume the interrupted level");

  chk_pin0_wake: assert property (
    mode_deep && src_event_i[iep_pkg::SRC_PIN0] &&
    main_enable_reg[iep_pkg::POS_PIN0_EN] |=> wake_o ##1 1'b1)
    else $error("pin 0 event did not wake from halt or stop");

  chk_deep_pins_only: assert property (
    mode_deep && !pin_wake |=> !wake_o)
    else $error("non-pin source woke from halt or stop");

  chk_port_masked: assert property (
    !wr_flo && !src_event_i[iep_pkg::SRC_PORT1] &&
    !irq_flag[iep_pkg::SRC_PORT1] &&
    (p1_change_i & port_pin_wake_enable[3:0]) == 4'h0 |=>
      !irq_flag[iep_pkg::SRC_PORT1])
    else $error("disabled port pin set the port flag");

  cov_preempt: cover property (take && svc_any);
  cov_two_nested: cover property ($countones(in_service) >= 2);
  cov_deep_wake: cover property (mode_deep && next_wake);
  cov_bus_write: cover property (wr_main);

endmodule
`default_nettype wire

//--- testbench/iep_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module iep_cpu_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [3:0] wait_i,
  input  wire logic       ret_cmd_i,
  output logic            ack_o,
  output logic            reti_o
);
  logic [3:0] cnt;
  // takes a request only while it is shown, after wait_i cycles of it
  wire        take = req_i && !ack_o && (cnt >= wait_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !req_i || ack_o)
      cnt <= 4'h0;
    else if (cnt != 4'hf)
      cnt <= cnt + 4'h1;
  end

  always_ff @(posedge clk_i)
  begin
    ack_o  <= !rst_i && take;
    reti_o <= !rst_i && ret_cmd_i;
  end
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i, rst_i, cyc, stb, we, ret_cmd;
  logic [9:0]  adr;
  logic [3:0]  sel, p1c, wt, id;
  logic [31:0] dat, rdat;
  logic [11:0] ev;
  logic [1:0]  mode, lvl;
  logic        ack, req, wake, irq, cack, creti;
  logic [7:0]  r;
  int          mismatches, n_checks;
  logic [7:0]  rq[$];
  logic [5:0]  dq[$];

  iep_interrupt_enable_priority uut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .ack_o(ack), .dat_o(rdat),
    .src_event_i(ev), .p1_change_i(p1c), .cpu_mode_i(mode),
    .cpu_ack_i(cack), .cpu_reti_i(creti), .irq_req_o(req),
    .irq_id_o(id), .irq_level_o(lvl), .wake_o(wake), .irq_o(irq)
  );

  iep_cpu_model cpu (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req), .wait_i(wt),
    .ret_cmd_i(ret_cmd), .ack_o(cack), .reti_o(creti)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(string what, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wb(logic w, logic [7:0] i, logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {i, 2'b00};
    dat <= {24'h0, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      mismatches++;
      print_verdict();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(logic [7:0] i, logic [7:0] e);
    rq.push_back(e);
    wb(1'b0, i, 8'h00);
  endtask

  task automatic evt(int s);
    @(posedge clk_i);
    ev <= 12'h001 << s;
    @(posedge clk_i);
    ev <= 12'h000;
  endtask

  task automatic settle();
    @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // a request that must be held shows no irq_req_o after the two-edge path
  task automatic held();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    cmp("request", 8'h00, {7'h0, req});
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (dq.size() != 0 && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    if (dq.size() != 0)
    begin
      mismatches++;
      print_verdict();
    end
  endtask

  task automatic reti();
    @(posedge clk_i);
    ret_cmd <= 1'b1;
    @(posedge clk_i);
    ret_cmd <= 1'b0;
  endtask

  always @(posedge clk_i)
  begin
    if (ack === 1'b1 && we === 1'b0 && rq.size() > 0)
      cmp("read data", rq.pop_front(), rdat[7:0]);
  end

  always @(posedge clk_i)
  begin
    if (cack === 1'b1)
    begin
      if (dq.size() == 0)
        cmp("spare dispatch", 8'h00, {7'h0, cack});
      else
        cmp("dispatch", {2'b00, dq.pop_front()}, {2'b00, id, lvl});
    end
  end

  initial
  begin
    {rst_i, cyc, stb, we, ret_cmd} = 5'b10000;
    {adr, sel, dat, ev, p1c, wt} = '0;
    sel = 4'hf;
    mode = iep_pkg::MODE_RUN;
    mismatches = 0;
    n_checks = 0;
    void'($urandom(67));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(iep_pkg::IDX_PORT_WAKE, iep_pkg::RST_BYTE);
    rd(iep_pkg::IDX_MAIN_EN, iep_pkg::RST_BYTE);
    rd(iep_pkg::IDX_AUX_EN, iep_pkg::RST_BYTE);
    rd(8'h10, 8'h00);
    wb(1'b1, iep_pkg::IDX_PORT_WAKE, 8'h0f);
    rd(iep_pkg::IDX_PORT_WAKE, 8'h0f);
    wb(1'b1, iep_pkg::IDX_MAIN_EN, 8'hff);
    rd(iep_pkg::IDX_MAIN_EN, 8'hbf);
    wb(1'b1, iep_pkg::IDX_MAIN_EN, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      r = 8'($urandom);
      wb(1'b1, iep_pkg::IDX_PRIO_LO_M + 8'(i), r);
      rd(iep_pkg::IDX_PRIO_LO_M + 8'(i), r & 8'h3f);
    end
    // timer1 at level 2 (10), serial1 at level 1 (01), rest level 0
    wb(1'b1, iep_pkg::IDX_PRIO_HI_M, 8'h08);
    wb(1'b1, iep_pkg::IDX_PRIO_LO_M, 8'h10);
    wb(1'b1, iep_pkg::IDX_PRIO_LO_A, 8'h00);
    wb(1'b1, iep_pkg::IDX_PRIO_HI_A, 8'h00);
    evt(1);
    held();
    rd(iep_pkg::IDX_FLAG_LO, 8'h02);
    dq.push_back({4'd1, 2'd0});
    wb(1'b1, iep_pkg::IDX_MAIN_EN, 8'h9a);
    drain();
    rd(iep_pkg::IDX_SERVICE, 8'h01);
    wt <= 4'h5;
    dq.push_back({4'd3, 2'd2});
    evt(3);
    drain();
    rd(iep_pkg::IDX_SERVICE, 8'h05);
    evt(4);
    held();
    dq.push_back({4'd4, 2'd1});
    reti();
    drain();
    rd(iep_pkg::IDX_SERVICE, 8'h03);
    reti();
    reti();
    rd(iep_pkg::IDX_SERVICE, 8'h00);
    rd(iep_pkg::IDX_EVT_STAT, 8'h03);
    settle();
    cmp("irq masked", 8'h00, {7'h0, irq});
    wb(1'b1, iep_pkg::IDX_EVT_MASK, 8'h01);
    settle();
    cmp("irq raised", 8'h01, {7'h0, irq});
    wb(1'b1, iep_pkg::IDX_EVT_STAT, 8'h03);
    settle();
    cmp("irq cleared", 8'h00, {7'h0, irq});
    wb(1'b1, iep_pkg::IDX_MAIN_EN, 8'h03);
    mode <= iep_pkg::MODE_HALT;
    evt(0);
    @(negedge clk_i);
    cmp("pin0 wake", 8'h01, {7'h0, wake});
    evt(1);
    @(negedge clk_i);
    cmp("timer wake", 8'h00, {7'h0, wake});
    @(posedge clk_i);
    mode <= iep_pkg::MODE_STOP;
    p1c <= 4'h4;
    @(posedge clk_i);
    p1c <= 4'h0;
    @(negedge clk_i);
    cmp("port wake", 8'h01, {7'h0, wake});
    repeat (5) @(posedge clk_i);
    cmp("left dispatches", 8'h00, 8'(dq.size()));
    print_verdict();
  end
endmodule
`default_nettype wire
